// >>> bench/sfb_flash_model.sv
/*
 * Burst flash model: drives numbered words while output enable is low.
 * Assumes registered controller pins on pclk and a latched address on strobe.
 */
`include "sfb_cfg.svh"

module sfb_flash_model
	import sfb_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Flash pins
	input wire sfb_flash_out_s fo,
	output logic [`SFB_DW-1:0] data_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [25:0] a = 26'h0;
	logic [2:0] k = 3'h0;
	logic lv = 1'b0;
	logic lo = 1'b1;
	// Next word follows each flash clock rise seen while enabled; a divided rise
	// that lands with the enable edge is not a data edge, word zero is still due
	always @(posedge pclk) begin
		lv <= fo.flash_clock_out;
		lo <= fo.output_enable_n;
		if (!fo.column_strobe_pin_n) begin
			a <= fo.address_bus;
			k <= 3'h0;
		end
		if (!fo.output_enable_n && (fo.flash_clk_run || (fo.flash_clock_out && !lv && !lo)))
			k <= k + 3'h1;
	end
	// Released bus shows the inverse, so a late sample cannot pass by luck
	assign data_bus = fo.output_enable_n ? ~{a, 3'h0, k} : {a, 3'h0, k};
endmodule // sfb_flash_model

// >>> bench/sfb_read_seq_tb_top.sv
/*
 * Testbench of the burst-read sequencer: APB tasks, pin monitor, flash model.
 * Assumes the package and design files are compiled before it.
 */
`include "sfb_cfg.svh"

module sfb_read_seq_tb_top
	import sfb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [`SFB_PAW-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	sfb_apb_rsp_s apb_rsp;
	sfb_flash_out_s fo;
	logic [`SFB_DW-1:0] data_bus;
	logic [31:0] rd;
	logic err;
	logic lv = 1'b0;
	logic adv_seen, oe_seen;
	int errors = 0;
	int num_checks = 0;
	int m_lead, m_adv, m_os, m_ceh;
	int m_per = 0;
	int pc = 0;

	always #5 pclk = ~pclk;

	sfb_read_seq dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.apb_rsp(apb_rsp), .flash_out(fo), .data_bus(data_bus));
	sfb_flash_model flash_u (.pclk(pclk), .fo(fo), .data_bus(data_bus));

	// Mid-cycle sampling keeps the monitor clear of edge races
	always @(negedge pclk) begin
		if (fo.flash_clock_out && !lv) begin
			m_per = pc;
			pc = 1;
		end else
			pc++;
		lv = fo.flash_clock_out;
		if (!fo.chip_select_n) begin
			if (!fo.column_strobe_pin_n) begin
				m_adv++;
				adv_seen = 1'b1;
			end else if (!adv_seen)
				m_lead++;
			else if (!fo.output_enable_n)
				oe_seen = 1'b1;
			else if (!oe_seen)
				m_os++;
			else
				m_ceh++;
		end
	end

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 20);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (apb_rsp.pready !== 1'b1) begin
			errors++;
			final_report();
		end
		@(posedge pclk);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask

	initial begin
		int ratio, code, exp_os, n;
		logic [3:0] f;
		logic [2:0] ln;
		logic [25:0] ad;
		logic [31:0] sample;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk("refresh", `SFB_OFF_REFRESH, 32'h0);
		rd_chk("config", `SFB_OFF_FLCFG, 32'h4);
		rd_chk("command", `SFB_OFF_CMD, 32'h70);
		rd_chk("status", `SFB_OFF_STATUS, 32'h0);
		apb(1'b1, 8'h18, 32'hffff_ffff);
		chk("write err", 32'h1, 32'(err));
		rd_chk("unmapped", 8'h18, 32'h0);
		chk("read err", 32'h1, 32'(err));
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			ratio = (i < 2) ? 1 : (i < 4) ? 2 : 4;
			f = (i % 2) ? 4'h7 : 4'h4;
			ln = (i % 2) ? 3'h7 : 3'h0;
			ad = 26'h2a55a5 + 26'(i);
			code = int'(f) - 1;
			if (ratio == 4)
				exp_os = (code < 5) ? code * 4 - 7 : (code - 2) * 4;
			else
				exp_os = ((code < 5) ? code - 1 : code - 2) * ratio;
			apb(1'b1, `SFB_OFF_REFRESH, 32'(i / 2));
			apb(1'b1, `SFB_OFF_FLCFG, 32'(f));
			apb(1'b1, `SFB_OFF_ADDR, 32'(ad));
			{m_lead, m_adv, m_os, m_ceh} = '0;
			{adv_seen, oe_seen} = 2'b00;
			apb(1'b1, `SFB_OFF_CMD, {25'h0, ln, 4'h1});
			if (i == 7)
				apb(1'b1, `SFB_OFF_CMD, 32'h1);
			n = 0;
			do begin
				apb(1'b0, `SFB_OFF_STATUS, 32'h0);
				n++;
			end while (rd[1] !== 1'b1 && n < 100);
			chk("status", {20'h0, {1'b0, ln} + 4'h1, 8'h02}, rd);
			chk("lead", 32'h1, 32'(m_lead >= 1 && m_lead <= ratio));
			chk("strobe", 32'(2 * ratio - 1), 32'(m_adv));
			chk("oe delay", 32'(exp_os), 32'(m_os));
			chk("cs hold", 32'(4 * ratio), 32'(m_ceh));
			if (ratio == 1)
				chk("clk run", 32'h1, 32'(fo.flash_clk_run));
			else
				chk("period", 32'(ratio), 32'(m_per));
			rd_chk("data", `SFB_OFF_DATA, {ad, 3'h0, ln});
			if (n >= 100) begin
				errors++;
				final_report();
			end
		end
		$display("test reads done");
		// With the divider at four a free-running pin would move within six clocks
		clk_en <= 1'b0;
		@(posedge pclk);
		sample = 32'(fo);
		repeat (6) @(posedge pclk);
		chk("freeze", sample, 32'(fo));
		clk_en <= 1'b1;
		@(posedge pclk);
		$display("test freeze done");
		final_report();
	end
endmodule // sfb_read_seq_tb_top

// >>> hw/sfb_cfg.svh
/*
 * Constants of the synchronous flash burst-read sequencer: widths, register
 * offsets, field positions, reset values and fixed timing counts.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef SFB_CFG_SVH
`define SFB_CFG_SVH

`define SFB_AW 26
`define SFB_DW 32
`define SFB_PAW 8

// Register byte offsets
`define SFB_OFF_REFRESH 8'h00
`define SFB_OFF_FLCFG 8'h04
`define SFB_OFF_ADDR 8'h08
`define SFB_OFF_CMD 8'h0c
`define SFB_OFF_STATUS 8'h10
`define SFB_OFF_DATA 8'h14

// Field positions
`define SFB_BIT_HALF 0
`define SFB_BIT_QUARTER 1
`define SFB_LAT_MSB 3
`define SFB_LAT_LSB 0
`define SFB_CMD_START 0
`define SFB_LEN_MSB 6
`define SFB_LEN_LSB 4
`define SFB_ST_BUSY 0
`define SFB_ST_DONE 1
`define SFB_ST_WMSB 11
`define SFB_ST_WLSB 8

// Reset values
`define SFB_RST_REFRESH 2'h0
`define SFB_RST_LAT 4'h4
`define SFB_RST_LEN 3'h7

// Latency field to latency code
`define SFB_LAT_BIAS 4'h1
`define SFB_CODE_MIN 4'h2
`define SFB_CODE_SPLIT 4'h5
`define SFB_OS_SUB_LO 6'h01
`define SFB_OS_SUB_HI 6'h02
`define SFB_OS_SUB_Q 6'h07
`define SFB_OS_MIN 6'h01
`define SFB_FIELD_CODE3 4'h4
`define SFB_CODE3 4'h3

// Address-valid strobe width per ratio, in memory clocks
`define SFB_ADV_W1 6'h01
`define SFB_ADV_W2 6'h03
`define SFB_ADV_W4 6'h07

// Output-enable release to chip-select release, in memory clocks
`define SFB_CEH_1 6'h04
`define SFB_CEH_2 6'h08
`define SFB_CEH_4 6'h10

`endif

// >>> hw/sfb_clkdiv.sv
/*
 * Flash clock divider: divides the memory clock by 1, 2 or 4 and marks the
 * memory clock cycle in which the forwarded clock has just risen.
 * Assumes the ratio is held steady while a read is in progress.
 */
module sfb_clkdiv
	import sfb_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Ratio
	input wire sfb_ratio_e ratio,
	// Divided clock
	output logic level,
	output logic tick
);
	sfb_div_s st;
	sfb_div_s next_st;
	logic [1:0] mask;
	logic [1:0] half;

	always_comb begin
		mask = 2'h0;
		half = 2'h0;
		unique case (ratio)
			SFB_DIV2: begin
				mask = 2'h1;
				half = 2'h1;
			end
			SFB_DIV4: begin
				mask = 2'h3;
				half = 2'h2;
			end
			default: begin
				mask = 2'h0;
				half = 2'h0;
			end
		endcase
		next_st.phase = (st.phase + 2'h1) & mask;
		// At divide-by-one the pad clock is the memory clock itself
		next_st.level = (ratio == SFB_DIV1) ? 1'b1 : (next_st.phase < half);
		next_st.tick = (next_st.phase == 2'h0);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign level = st.level;
	assign tick = st.tick;

endmodule // sfb_clkdiv

// >>> hw/sfb_pkg.sv
/*
 * Types of the synchronous flash burst-read sequencer.
 * Assumes sfb_cfg.svh is on the include path.
 */
`include "sfb_cfg.svh"

package sfb_pkg;

	typedef enum logic [1:0] {
		SFB_DIV1 = 2'b00,
		SFB_DIV2 = 2'b01,
		SFB_DIV4 = 2'b10
	} sfb_ratio_e;

	typedef enum logic [5:0] {
		SFB_IDLE = 6'b000001,
		SFB_LEAD = 6'b000010,
		SFB_ADV = 6'b000100,
		SFB_OS = 6'b001000,
		SFB_BURST = 6'b010000,
		SFB_CEH = 6'b100000
	} sfb_state_e;

	typedef struct packed {
		logic flash_clock_out;
		logic flash_clk_run;
		logic column_strobe_pin_n;
		logic output_enable_n;
		logic chip_select_n;
		logic [`SFB_AW-1:0] address_bus;
	} sfb_flash_out_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sfb_apb_rsp_s;

	typedef struct packed {
		logic [1:0] phase;
		logic level;
		logic tick;
	} sfb_div_s;

	typedef struct packed {
		sfb_state_e state;
		logic [1:0] refresh;
		logic [3:0] lat_field;
		logic [`SFB_AW-1:0] addr;
		logic [2:0] len;
		sfb_ratio_e ratio;
		logic [5:0] cnt;
		logic [5:0] os_delay;
		logic [3:0] words;
		logic done;
		logic [`SFB_DW-1:0] data;
		sfb_flash_out_s pins;
		sfb_apb_rsp_s apb;
	} sfb_seq_s;

endpackage

// >>> hw/sfb_read_seq.sv
/*
 * Synchronous flash burst-read sequencer with its APB register file.
 * Assumes an APB master on pclk and a burst flash on the pins; data_bus
 * is synchronous to pclk.
 */
// Design decisions made here: the register addresses and the APB interface to the registers.
// Operation
// - Flash clock is memory clock divided 1/2/4
// - Quarter select wins, half next, else one
// - Address-valid strobe low 1/3/7 memory clocks
// - Chip select releases 4/8/16 after OE
// - OE delay from strobe per code formula
// - Latency code comes from config latency field
// - Latency field 0b0100 means code three
// - Code counts flash clocks to first data
`include "sfb_cfg.svh"

module sfb_read_seq
	import sfb_pkg::*;
(
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SFB_PAW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output sfb_apb_rsp_s apb_rsp,
	// Flash pins
	output sfb_flash_out_s flash_out,
	input wire logic [`SFB_DW-1:0] data_bus
);
	sfb_seq_s st;
	sfb_seq_s next_st;
	sfb_ratio_e live_ratio;
	sfb_ratio_e div_ratio;
	logic div_level;
	logic div_tick;
	logic [3:0] code;
	logic [5:0] os_calc;
	logic [5:0] adv_w;
	logic [5:0] ceh_w;
	logic setup;
	logic wr;
	logic [31:0] rd;
	logic mapped;

	// Quarter select overrides half select
	always_comb begin
		if (st.refresh[`SFB_BIT_QUARTER]) begin
			live_ratio = SFB_DIV4;
		end else if (st.refresh[`SFB_BIT_HALF]) begin
			live_ratio = SFB_DIV2;
		end else begin
			live_ratio = SFB_DIV1;
		end
	end

	// A read in flight keeps the ratio it started with
	assign div_ratio = (st.state == SFB_IDLE) ? live_ratio : st.ratio;

	sfb_clkdiv u_div (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.ratio(div_ratio),
		.level(div_level),
		.tick(div_tick)
	);

	// Field 0b0100 gives code 3; codes below 2 would make a zero or wrapped delay
	always_comb begin
		code = st.lat_field - `SFB_LAT_BIAS;
		if (st.lat_field < (`SFB_CODE_MIN + `SFB_LAT_BIAS)) begin
			code = `SFB_CODE_MIN;
		end
	end

	always_comb begin
		os_calc = {2'h0, code} - `SFB_OS_SUB_LO;
		unique case (live_ratio)
			SFB_DIV2: begin
				if (code < `SFB_CODE_SPLIT) begin
					os_calc = 6'(({2'h0, code} - `SFB_OS_SUB_LO) << 1);
				end else begin
					os_calc = 6'(({2'h0, code} - `SFB_OS_SUB_HI) << 1);
				end
			end
			SFB_DIV4: begin
				if (code < `SFB_CODE_SPLIT) begin
					os_calc = 6'(({2'h0, code} << 2) - `SFB_OS_SUB_Q);
				end else begin
					os_calc = 6'(({2'h0, code} - `SFB_OS_SUB_HI) << 2);
				end
			end
			default: begin
				if (code >= `SFB_CODE_SPLIT) begin
					os_calc = {2'h0, code} - `SFB_OS_SUB_HI;
				end
			end
		endcase
		if (os_calc < `SFB_OS_MIN) begin
			os_calc = `SFB_OS_MIN;
		end
	end

	always_comb begin
		unique case (st.ratio)
			SFB_DIV2: begin
				adv_w = `SFB_ADV_W2;
				ceh_w = `SFB_CEH_2;
			end
			SFB_DIV4: begin
				adv_w = `SFB_ADV_W4;
				ceh_w = `SFB_CEH_4;
			end
			default: begin
				adv_w = `SFB_ADV_W1;
				ceh_w = `SFB_CEH_1;
			end
		endcase
	end

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite && st.apb.pready && mapped;

	always_comb begin
		mapped = 1'b1;
		rd = 32'h0;
		unique case (paddr)
			`SFB_OFF_REFRESH: rd[1:0] = st.refresh;
			`SFB_OFF_FLCFG: rd[`SFB_LAT_MSB:`SFB_LAT_LSB] = st.lat_field;
			`SFB_OFF_ADDR: rd[`SFB_AW-1:0] = st.addr;
			`SFB_OFF_CMD: rd[`SFB_LEN_MSB:`SFB_LEN_LSB] = st.len;
			`SFB_OFF_STATUS: begin
				rd[`SFB_ST_BUSY] = (st.state != SFB_IDLE);
				rd[`SFB_ST_DONE] = st.done;
				rd[`SFB_ST_WMSB:`SFB_ST_WLSB] = st.words;
			end
			`SFB_OFF_DATA: rd[`SFB_DW-1:0] = st.data;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		next_st = st;
		// Zero-wait answer: ready and data are prepared during setup
		next_st.apb.pready = setup;
		next_st.apb.pslverr = setup && !mapped;
		next_st.apb.prdata = setup ? rd : 32'h0;
		if (wr) begin
			unique case (paddr)
				`SFB_OFF_REFRESH: next_st.refresh = pwdata[1:0];
				`SFB_OFF_FLCFG: next_st.lat_field = pwdata[`SFB_LAT_MSB:`SFB_LAT_LSB];
				`SFB_OFF_ADDR: next_st.addr = pwdata[`SFB_AW-1:0];
				`SFB_OFF_CMD: begin
					if (st.state == SFB_IDLE) begin
						next_st.len = pwdata[`SFB_LEN_MSB:`SFB_LEN_LSB];
					end
				end
				default: next_st.refresh = st.refresh;
			endcase
		end
		next_st.pins.flash_clock_out = div_level;
		next_st.pins.flash_clk_run = (div_ratio == SFB_DIV1);
		unique case (st.state)
			SFB_IDLE: begin
				// A start while busy is dropped, and so is the write to the length
				if (wr && paddr == `SFB_OFF_CMD && pwdata[`SFB_CMD_START]) begin
					next_st.ratio = live_ratio;
					next_st.os_delay = os_calc;
					next_st.done = 1'b0;
					next_st.words = 4'h0;
					next_st.pins.address_bus = st.addr;
					next_st.pins.chip_select_n = 1'b0;
					next_st.state = SFB_LEAD;
				end
			end
			SFB_LEAD: begin
				// Wait for a flash clock rise, so the lead is 1 to ratio clocks
				if (div_tick) begin
					next_st.pins.column_strobe_pin_n = 1'b0;
					next_st.cnt = adv_w - 6'h01;
					next_st.state = SFB_ADV;
				end
			end
			SFB_ADV: begin
				if (st.cnt == 6'h00) begin
					next_st.pins.column_strobe_pin_n = 1'b1;
					next_st.cnt = st.os_delay - 6'h01;
					next_st.state = SFB_OS;
				end else begin
					next_st.cnt = st.cnt - 6'h01;
				end
			end
			SFB_OS: begin
				if (st.cnt == 6'h00) begin
					next_st.pins.output_enable_n = 1'b0;
					next_st.state = SFB_BURST;
				end else begin
					next_st.cnt = st.cnt - 6'h01;
				end
			end
			SFB_BURST: begin
				// The latency has elapsed by now, so each rise carries a word
				if (div_tick) begin
					next_st.data = data_bus;
					next_st.words = st.words + 4'h1;
					if (st.words[2:0] == st.len) begin
						next_st.pins.output_enable_n = 1'b1;
						next_st.cnt = ceh_w - 6'h01;
						next_st.state = SFB_CEH;
					end
				end
			end
			SFB_CEH: begin
				if (st.cnt == 6'h00) begin
					next_st.pins.chip_select_n = 1'b1;
					next_st.done = 1'b1;
					next_st.state = SFB_IDLE;
				end else begin
					next_st.cnt = st.cnt - 6'h01;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.state <= SFB_IDLE;
			st.refresh <= `SFB_RST_REFRESH;
			st.lat_field <= `SFB_RST_LAT;
			st.len <= `SFB_RST_LEN;
			st.ratio <= SFB_DIV1;
			st.os_delay <= `SFB_OS_MIN;
			st.pins.column_strobe_pin_n <= 1'b1;
			st.pins.output_enable_n <= 1'b1;
			st.pins.chip_select_n <= 1'b1;
			st.pins.flash_clk_run <= 1'b1;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign apb_rsp = st.apb;
	assign flash_out = st.pins;

	// Checking helpers: run lengths of pin phases
	logic [5:0] adv_run;
	logic [5:0] gap_run;
	logic [5:0] ceh_run;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adv_run <= 6'h00;
			gap_run <= 6'h00;
			ceh_run <= 6'h00;
		end else if (clk_en) begin
			adv_run <= st.pins.column_strobe_pin_n ? 6'h00 : adv_run + 6'h01;
			gap_run <= (st.state == SFB_OS) ? gap_run + 6'h01 : 6'h00;
			ceh_run <= (st.state == SFB_CEH) ? ceh_run + 6'h01 : 6'h00;
		end
	end

	property p_adv_width;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		$rose(st.pins.column_strobe_pin_n) |-> adv_run == adv_w;
	endproperty
	a_adv_width: assert property (p_adv_width) else $error("strobe width wrong");

	property p_os_delay;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		$fell(st.pins.output_enable_n) |-> gap_run == st.os_delay;
	endproperty
	a_os_delay: assert property (p_os_delay) else $error("oe delay wrong");

	property p_ceh;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		$rose(st.pins.chip_select_n) |-> ceh_run == ceh_w && st.pins.output_enable_n;
	endproperty
	a_ceh: assert property (p_ceh) else $error("cs hold wrong");

	property p_lead;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		$fell(st.pins.column_strobe_pin_n) |-> $past(!st.pins.chip_select_n)
			&& st.pins.address_bus == st.addr;
	endproperty
	a_lead: assert property (p_lead) else $error("no lead before strobe");

	property p_div4;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		div_tick && st.state == SFB_BURST && st.ratio == SFB_DIV4 |=>
			!div_tick [*3] ##1 div_tick;
	endproperty
	a_div4: assert property (p_div4) else $error("divide by four broken");

	property p_div2;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		div_tick && st.state == SFB_OS && st.ratio == SFB_DIV2 |=>
			!div_tick ##1 div_tick;
	endproperty
	a_div2: assert property (p_div2) else $error("divide by two broken");

	property p_quarter_wins;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		st.refresh[`SFB_BIT_QUARTER] && st.state == SFB_IDLE |-> div_ratio == SFB_DIV4;
	endproperty
	a_quarter_wins: assert property (p_quarter_wins) else $error("ratio select wrong");

	property p_code3;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		st.lat_field == `SFB_FIELD_CODE3 |-> code == `SFB_CODE3;
	endproperty
	a_code3: assert property (p_code3) else $error("latency code wrong");

	property p_capture;
		@(posedge pclk) disable iff (!presetn || !clk_en)
		$past(st.state) == SFB_BURST && st.words != $past(st.words) |->
			$past(div_tick) && st.data == $past(data_bus);
	endproperty
	a_capture: assert property (p_capture) else $error("capture off flash edge");

	c_div1: cover property (@(posedge pclk) st.ratio == SFB_DIV1 && $rose(st.done));
	c_div2: cover property (@(posedge pclk) st.ratio == SFB_DIV2 && $rose(st.done));
	c_div4: cover property (@(posedge pclk) st.ratio == SFB_DIV4 && $rose(st.done));
	c_err: cover property (@(posedge pclk) st.apb.pslverr);

endmodule // sfb_read_seq
